/* File: verilog/cvf_pkg.sv */
// Constants and types shared by both ends of the component video format converter.
// Assumes one 100 MHz sample clock shared by both ends.
package cvf_pkg;
  localparam int CVF_W = 8;              // Sample word width, 256-level scale
  localparam int CVF_CODE_MIN = 0;       // Studio code kept for sync words
  localparam int CVF_CODE_MAX = 255;     // Studio code kept for sync words
  localparam int CVF_Y_BLACK = 16;       // Black level in both codings
  localparam int CVF_STUDIO_Y_SPAN = 219;
  localparam int CVF_STUDIO_Y_MAX = CVF_Y_BLACK + CVF_STUDIO_Y_SPAN;
  localparam int CVF_C_ZERO = 128;       // Studio colour-difference zero
  localparam int CVF_C_MIN = 16;         // 225-level chroma span lower end
  localparam int CVF_C_MAX = 240;        // 225-level chroma span upper end
  localparam int CVF_STUDIO_CF_Y = 219;
  localparam int CVF_STUDIO_CF_U = 126;
  localparam int CVF_STUDIO_CF_V = 160;
  localparam int CVF_RCV_CF_Y = 192;
  localparam int CVF_RCV_CF_U = 144;     // Three quarters of 192
  localparam int CVF_RCV_CF_V = 192;
  localparam int CVF_GAIN_SHIFT = 8;
  // Gains in 1/256 steps, rounded to nearest
  localparam int CVF_Y_GAIN =
    (CVF_RCV_CF_Y * 256 + CVF_STUDIO_CF_Y / 2) / CVF_STUDIO_CF_Y;
  localparam int CVF_U_GAIN =
    (CVF_RCV_CF_U * 256 + CVF_STUDIO_CF_U / 2) / CVF_STUDIO_CF_U;
  localparam int CVF_V_GAIN =
    (CVF_RCV_CF_V * 256 + CVF_STUDIO_CF_V / 2) / CVF_STUDIO_CF_V;
  localparam int CVF_BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    CVF_PH_CB = 2'b00,
    CVF_PH_Y0 = 2'b01,
    CVF_PH_CR = 2'b10,
    CVF_PH_Y1 = 2'b11
  } cvf_phase_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
    logic first;
  } cvf_beat_t;
endpackage

/* File: verilog/cvf_link_if.sv */
// Receiver-coded pixel link between the converter and downstream logic.
// Assumes both ends run on clk_sys; no clocking block.
`timescale 1ns/10ps
interface cvf_link_if;
  logic valid;       // Beat present
  logic ready;       // Receiver takes beat
  logic [7:0] y;     // Luma, straight binary
  logic [7:0] c;     // Chroma word or nibble in c[3:0]
  logic first;       // First chroma beat of a group
  modport dev (output valid, output y, output c, output first, input ready);
  modport rcv (input valid, input y, input c, input first, output ready);
endinterface

/* File: verilog/cvf_dev.sv */
// Converter end: studio word multiplex in, receiver-coded 4:2:2 or 4:1:1 beats out.
// Assumes inputs synchronous to clk_sys and a sink that honours valid/ready.
//
// Summary of operation
// - Samples are 8-bit words, 256-level scale.
// - Studio codes 0 and 255 never video.
// - Studio luma spans 220 levels, black 16.
// - Studio chroma 225 levels, zero at 128.
// - Studio gains 219+16, 126+128, 160+128.
// - Studio stream order Cb, Y, Cr, Y.
// - First three cosited; fourth next luma.
// - Output luma is 192 times Y plus 16.
// - Output chroma two's complement, 144 and 192.
// - Offset to two's complement flips MSB only.
// - Output multiplex in 4:1:1 or 4:2:2.
// - Decoded red difference scaled three quarters, one adder.
// - Downstream finishes three-quarter chroma equalisation.
// - Data at luma rate; luma eight lines.
`timescale 1ns/10ps
module cvf_dev
  import cvf_pkg::*;
(
  input wire logic clk_sys,                   // Sample clock
  input wire logic rstn,                      // Async reset, active low
  input wire logic [cvf_pkg::CVF_W-1:0] in_word, // Studio multiplex word
  input wire logic in_valid,                  // in_word present
  input wire logic in_sync,                   // in_word is a Cb word
  output logic in_ready,                      // Converter takes in_word
  input wire logic fmt_411,                   // 1: 4:1:1 output, 0: 4:2:2
  input wire logic mode_decoded,              // 1: input is decoder-coded
  output logic code_err,                      // Pulse: reserved code seen
  cvf_link_if.dev link                        // Receiver-coded output
);
  import cvf_pkg::*;

  typedef struct packed {
    cvf_phase_t phase;
    logic grp;
    logic [7:0] cb;
    logic [7:0] y0;
    logic [7:0] u_hold;
    logic [7:0] v_hold;
    logic [CVF_BUF_DEPTH-1:0] ent_v;
    cvf_beat_t [CVF_BUF_DEPTH-1:0] ent;
    logic in_ready;
    logic code_err;
  } cvf_dev_st_t;

  cvf_dev_st_t s;
  cvf_dev_st_t next_s;

  function automatic logic [7:0] cvf_sat_u8(input int v);
    if (v < 0) begin
      return 8'h00;
    end else if (v > CVF_CODE_MAX) begin
      return 8'hFF;
    end
    return 8'(v);
  endfunction

  // Studio word with reserved codes pulled one step inward
  function automatic logic [7:0] cvf_clean(input logic [7:0] d);
    if (int'(d) == CVF_CODE_MIN) begin
      return 8'(CVF_CODE_MIN + 1);
    end else if (int'(d) == CVF_CODE_MAX) begin
      return 8'(CVF_CODE_MAX - 1);
    end
    return d;
  endfunction

  function automatic logic [7:0] cvf_conv_y(input logic [7:0] d, input logic dec);
    int v;
    v = 0;
    if (dec) begin
      return d;
    end
    // Studio luma is confined to black..black+219 before rescaling
    v = int'(d);
    if (v < CVF_Y_BLACK) begin
      v = CVF_Y_BLACK;
    end else if (v > CVF_STUDIO_Y_MAX) begin
      v = CVF_STUDIO_Y_MAX;
    end
    v = ((v - CVF_Y_BLACK) * CVF_Y_GAIN) >>> CVF_GAIN_SHIFT;
    return cvf_sat_u8(v + CVF_Y_BLACK);
  endfunction

  function automatic logic [7:0] cvf_conv_c(input logic [7:0] d, input int gain,
                                            input logic dec, input logic is_v);
    int v;
    logic [7:0] ob;
    v = 0;
    ob = 8'h00;
    if (dec) begin
      if (!is_v) begin
        return d;
      end
      // Three quarters as v minus v/4: one adder, cannot overflow
      v = int'($signed(d));
      return 8'(v - (v >>> 2));
    end
    v = int'(d);
    if (v < CVF_C_MIN) begin
      v = CVF_C_MIN;
    end else if (v > CVF_C_MAX) begin
      v = CVF_C_MAX;
    end
    v = ((v - CVF_C_ZERO) * gain) >>> CVF_GAIN_SHIFT;
    ob = cvf_sat_u8(v + CVF_C_ZERO);
    return {~ob[7], ob[6:0]};
  endfunction

  always_comb begin
    logic [7:0] w;
    logic take;
    logic push;
    logic pop;
    cvf_phase_t ph;
    cvf_beat_t pb;
    logic [7:0] uc;
    logic [7:0] vc;
    w = 8'h00;
    take = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    ph = s.phase;
    pb = '0;
    uc = 8'h00;
    vc = 8'h00;
    next_s = s;
    next_s.code_err = 1'b0;

    take = in_valid && s.in_ready;
    w = mode_decoded ? in_word : cvf_clean(in_word);
    if (in_sync) begin
      ph = CVF_PH_CB;
    end
    if (take) begin
      if (!mode_decoded && (int'(in_word) == CVF_CODE_MIN ||
                            int'(in_word) == CVF_CODE_MAX)) begin
        next_s.code_err = 1'b1;
      end
      if (in_sync) begin
        next_s.grp = 1'b0;
      end
      unique case (ph)
        CVF_PH_CB: begin
          next_s.cb = w;
        end
        CVF_PH_Y0: begin
          next_s.y0 = w;
        end
        CVF_PH_CR: begin
          // Cb, Y0 and Cr describe one cosited position
          uc = cvf_conv_c(s.cb, CVF_U_GAIN, mode_decoded, 1'b0);
          vc = cvf_conv_c(w, CVF_V_GAIN, mode_decoded, 1'b1);
          if (!fmt_411 || !next_s.grp) begin
            next_s.u_hold = uc;
            next_s.v_hold = vc;
          end
          push = 1'b1;
          pb.y = cvf_conv_y(s.y0, mode_decoded);
          pb.first = !fmt_411 || !next_s.grp;
          if (!fmt_411) begin
            pb.c = uc;
          end else if (!next_s.grp) begin
            pb.c = {4'h0, uc[7:4]};
          end else begin
            pb.c = {4'h0, s.u_hold[3:0]};
          end
        end
        CVF_PH_Y1: begin
          // Fourth word is the next luma sample, paired with Cr
          push = 1'b1;
          pb.y = cvf_conv_y(w, mode_decoded);
          if (!fmt_411) begin
            pb.c = s.v_hold;
          end else if (!next_s.grp) begin
            pb.c = {4'h0, s.v_hold[7:4]};
          end else begin
            pb.c = {4'h0, s.v_hold[3:0]};
          end
          next_s.grp = fmt_411 ? !next_s.grp : 1'b0;
        end
      endcase
      next_s.phase = cvf_phase_t'(ph + 2'b01);
    end

    // Two-entry buffer; entry 0 always drives the link
    pop = s.ent_v[0] && link.ready;
    if (pop) begin
      next_s.ent[0] = s.ent[1];
      next_s.ent_v[0] = s.ent_v[1];
      next_s.ent_v[1] = 1'b0;
    end
    if (push) begin
      if (!next_s.ent_v[0]) begin
        next_s.ent[0] = pb;
        next_s.ent_v[0] = 1'b1;
      end else begin
        next_s.ent[1] = pb;
        next_s.ent_v[1] = 1'b1;
      end
    end
    // Ready is pessimistic by one cycle so it can come from a flop
    next_s.in_ready = !(next_s.ent_v[0] && next_s.ent_v[1]);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.in_ready;
  assign code_err = s.code_err;
  assign link.valid = s.ent_v[0];
  assign link.y = s.ent[0].y;
  assign link.c = s.ent[0].c;
  assign link.first = s.ent[0].first;
endmodule

/* File: verilog/cvf_rcv.sv */
// Downstream end: takes receiver-coded beats, rebuilds chroma, equalises V.
// Assumes fmt_411 matches the converter's setting.
`timescale 1ns/10ps
module cvf_rcv
  import cvf_pkg::*;
(
  input wire logic clk_sys,          // Sample clock
  input wire logic rstn,             // Async reset, active low
  cvf_link_if.rcv link,              // Receiver-coded input
  input wire logic fmt_411,          // 1: 4:1:1 input, 0: 4:2:2
  input wire logic hold,             // Stall the link
  output logic out_valid,            // Pulse: one luma sample out
  output logic [7:0] out_y,          // Luma, straight binary
  output logic [7:0] out_u,          // Last complete U, two's complement
  output logic [7:0] out_v,          // Last complete V, two's complement
  output logic [7:0] out_v_eq,       // V scaled to U's factor
  output logic range_err             // Pulse: luma below black
);
  import cvf_pkg::*;

  typedef struct packed {
    logic [1:0] k;
    logic [7:0] u_acc;
    logic [7:0] v_acc;
    logic ready;
    logic out_valid;
    logic [7:0] out_y;
    logic [7:0] out_u;
    logic [7:0] out_v;
    logic [7:0] out_v_eq;
    logic range_err;
  } cvf_rcv_st_t;

  cvf_rcv_st_t s;
  cvf_rcv_st_t next_s;

  always_comb begin
    logic [1:0] k;
    int v;
    k = 2'b00;
    v = 0;
    next_s = s;
    next_s.out_valid = 1'b0;
    next_s.range_err = 1'b0;
    next_s.ready = !hold;
    if (link.valid && s.ready) begin
      next_s.out_valid = 1'b1;
      next_s.out_y = link.y;
      next_s.range_err = int'(link.y) < CVF_Y_BLACK;
      k = link.first ? 2'b00 : s.k;
      if (!fmt_411) begin
        if (link.first) begin
          next_s.u_acc = link.c;
        end else begin
          next_s.out_u = s.u_acc;
          next_s.out_v = link.c;
          v = int'($signed(link.c));
          next_s.out_v_eq = 8'(v - (v >>> 2));
        end
      end else begin
        unique case (k)
          2'b00: next_s.u_acc[7:4] = link.c[3:0];
          2'b01: next_s.v_acc[7:4] = link.c[3:0];
          2'b10: next_s.u_acc[3:0] = link.c[3:0];
          2'b11: begin
            next_s.out_u = s.u_acc;
            next_s.out_v = {s.v_acc[7:4], link.c[3:0]};
            v = int'($signed({s.v_acc[7:4], link.c[3:0]}));
            next_s.out_v_eq = 8'(v - (v >>> 2));
          end
        endcase
      end
      next_s.k = k + 2'b01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.ready = s.ready;
  assign out_valid = s.out_valid;
  assign out_y = s.out_y;
  assign out_u = s.out_u;
  assign out_v = s.out_v;
  assign out_v_eq = s.out_v_eq;
  assign range_err = s.range_err;
endmodule

/* File: bench/cvf_link_checker.sv */
// Checker for the receiver-coded link between converter and downstream end.
// Assumes plain copies of the link signals, all on clk_sys, reset rstn.
`timescale 1ns/10ps
module cvf_link_checker (
  input wire logic clk_sys,      // Sample clock
  input wire logic rstn,         // Async reset, active low
  input wire logic valid,        // Beat present
  input wire logic ready,        // Beat taken
  input wire logic [7:0] y,      // Luma
  input wire logic [7:0] c,      // Chroma
  input wire logic first,        // First chroma beat
  input wire logic fmt_411,      // 1: 4:1:1 multiplex
  input wire logic mode_decoded  // Decoder-coded input, luma passes
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  chk_valid_hold: assert property (valid && !ready |=> valid)
    else $error("valid dropped while stalled");
  chk_luma_hold: assert property (valid && !ready |=> $stable(y))
    else $error("luma changed while stalled");
  chk_chroma_hold: assert property (valid && !ready |=> $stable(c))
    else $error("chroma changed while stalled");
  chk_first_hold: assert property (valid && !ready |=> $stable(first))
    else $error("first changed while stalled");
  chk_nibble_zero: assert property (valid && fmt_411 |-> c[7:4] == 4'h0)
    else $error("upper chroma nibble not zero");
  chk_first_alt: assert property (
    valid && ready && first && !fmt_411 |=> !(valid && first))
    else $error("two first beats in a row");
  // Converted luma can only land between black and black plus 191
  chk_luma_range: assert property (
    valid && !mode_decoded |-> y >= 8'h10 && y <= 8'hCF)
    else $error("luma outside converted range");
  chk_reset_idle: assert property ($rose(rstn) |-> !valid && !ready)
    else $error("link active at reset release");
endmodule

/* File: bench/component_video_format_converter_tb_top.sv */
// Testbench: studio groups in, receiver samples checked at the downstream end.
// Assumes both ends and the link interface from verilog/.
`timescale 1ns/10ps
module component_video_format_converter_tb_top;
  import cvf_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] in_word = 8'h00;
  logic in_valid = 1'b0, in_sync = 1'b0, fmt_411 = 1'b0, mode_decoded = 1'b0, hold = 1'b0;
  logic in_ready, code_err, out_valid, range_err;
  logic [7:0] out_y, out_u, out_v, out_v_eq;
  int bad_count = 0, n_compared = 0, n_cerr = 0, n_rerr = 0;
  logic [7:0] yq[$];
  logic [31:0] tv [4] = '{32'h801080EB, 32'h00FFFF00, 32'hF0641080, 32'h10EBF010};
  cvf_link_if link();
  cvf_dev i_cvf_dev (.clk_sys(clk_sys), .rstn(rstn), .in_word(in_word), .in_valid(in_valid),
    .in_sync(in_sync), .in_ready(in_ready), .fmt_411(fmt_411), .mode_decoded(mode_decoded),
    .code_err(code_err), .link(link));
  cvf_rcv i_cvf_rcv (.clk_sys(clk_sys), .rstn(rstn), .link(link), .fmt_411(fmt_411),
    .hold(hold), .out_valid(out_valid), .out_y(out_y), .out_u(out_u), .out_v(out_v),
    .out_v_eq(out_v_eq), .range_err(range_err));
  cvf_link_checker i_cvf_link_checker (.clk_sys(clk_sys), .rstn(rstn), .valid(link.valid),
    .ready(link.ready), .y(link.y), .c(link.c), .first(link.first), .fmt_411(fmt_411),
    .mode_decoded(mode_decoded));
  always #5 clk_sys = ~clk_sys;
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [7:0] ey(input logic [7:0] w);
    int v;
    v = (w < 16) ? 16 : (w > 235) ? 235 : w;
    return 8'((((v - 16) * CVF_Y_GAIN) >>> 8) + 16);
  endfunction
  function automatic logic [7:0] ec(input logic [7:0] w, input int g);
    int v;
    v = (w < 16) ? 16 : (w > 240) ? 240 : w;
    v = (((v - 128) * g) >>> 8) + 128;
    v = (v < 0) ? 0 : (v > 255) ? 255 : v;
    return 8'(v) ^ 8'h80;
  endfunction
  always @(posedge clk_sys) begin
    if (code_err === 1'b1) n_cerr++;
    if (range_err === 1'b1) n_rerr++;
    if (out_valid === 1'b1) begin
      if (yq.size() == 0) cmp(8'(yq.size()), 8'h01);
      else cmp(out_y, yq.pop_front());
    end
  end
  // Word is held until the registered ready was seen high at a falling edge and the next rising edge has passed
  task automatic put(input logic [7:0] w, input logic s);
    logic r;
    in_word <= w;
    in_sync <= s;
    in_valid <= 1'b1;
    do begin
      @(negedge clk_sys) r = in_ready;
      @(posedge clk_sys);
    end while (r !== 1'b1);
  endtask
  task automatic grp(input logic s, input logic [7:0] cb, y0, cr, y1);
    put(cb, s);
    put(y0, 1'b0);
    put(cr, 1'b0);
    put(y1, 1'b0);
    yq.push_back(mode_decoded ? y0 : ey(y0));
    yq.push_back(mode_decoded ? y1 : ey(y1));
  endtask
  task automatic drain;
    in_valid <= 1'b0;
    for (int i = 0; i < 300 && yq.size() > 0; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    cmp(8'(yq.size()), 8'h00);
  endtask
  task automatic chkc(input logic [7:0] eu, input logic [7:0] ev);
    cmp(out_u, eu);
    cmp(out_v, ev);
    cmp(out_v_eq, ev - 8'($signed(ev) >>> 2));
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    foreach (tv[i]) begin
      grp(1'b1, tv[i][31:24], tv[i][23:16], tv[i][15:8], tv[i][7:0]);
      drain;
      chkc(ec(tv[i][31:24], CVF_U_GAIN), ec(tv[i][15:8], CVF_V_GAIN));
    end
    cmp(8'(n_cerr), 8'h04);
    // Receiver stalls long enough for both buffer entries to fill
    hold <= 1'b1;
    fork
      begin
        grp(1'b1, 8'h60, 8'h20, 8'hA0, 8'h30);
        grp(1'b1, 8'h50, 8'h40, 8'hB0, 8'h50);
        grp(1'b1, 8'h70, 8'h60, 8'h90, 8'hC0);
      end
      begin
        repeat (40) @(posedge clk_sys);
        cmp({7'h00, in_ready}, 8'h00);
        hold <= 1'b0;
      end
    join
    drain;
    chkc(ec(8'h70, CVF_U_GAIN), ec(8'h90, CVF_V_GAIN));
    fmt_411 <= 1'b1;
    @(posedge clk_sys);
    grp(1'b1, 8'hC0, 8'h50, 8'h30, 8'h60);
    grp(1'b0, 8'h40, 8'h70, 8'hD0, 8'h80);
    drain;
    chkc(ec(8'hC0, CVF_U_GAIN), ec(8'h30, CVF_V_GAIN));
    fmt_411 <= 1'b0;
    mode_decoded <= 1'b1;
    @(posedge clk_sys);
    grp(1'b1, 8'h20, 8'h08, 8'h40, 8'h64);
    drain;
    cmp(out_u, 8'h20);
    cmp(out_v, 8'h30);
    cmp(8'(n_rerr), 8'h01);
    print_verdict;
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
endmodule
